// ### core/rmii_strap_led_pins.sv
`timescale 1ns/10ps
`include "pins_map.svh"

// small synchronous fifo, valid/ready on both sides
module rx_fifo #(
  parameter int WIDTH = `RX_FIFO_WIDTH,
  parameter int DEPTH = `RX_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// Behaviour
// R1: MAC drives two tx bits under enable
// R2: receive dibit, first output bit 0
// R3: receive error flags errored frame
// R4: carrier/data-valid while medium not idle
// R5: 10 Mbps: data low until SFD
// R6: no 10 Mbps half-duplex transmit echo
// R7: straps latched at both resets
// R8: three mode straps form mode field
// R9: management address from address strap
// R10: link indicator on, blinks on activity
// R11: speed indicator on only at 100
// R12: function strap picks interrupt or refclk
// R13: names beginning n are active low
// R14: management clock in, shared data line
// R15: reference clock output is 50 MHz; here a static enable, high once straps latch in clock mode
// R16: straps frozen until next reset
module rmii_strap_led_pins
  import pins_pkg::*;
#(
  parameter int BLINK_CYCLES = `BLINK_HALF_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic SYSTEM_RESET_N,
  input wire logic [1:0] TX_DATA,
  input wire logic TX_ENABLE,
  output logic [1:0] TX_DIBIT_OUT,
  output logic TX_VALID_OUT,
  input wire logic [1:0] LINE_DIBIT,
  input wire logic LINE_VALID,
  input wire logic LINE_ERROR,
  input wire logic LINE_ACTIVE,
  output logic LINE_READY,
  output logic [1:0] RX_DATA,
  output logic RX_DATA_OE_N,
  output logic RX_ERROR,
  output logic CARRIER_DATA_VALID,
  input wire logic OP_MODE_STRAP_BIT0,
  input wire logic OP_MODE_STRAP_BIT1,
  input wire logic OP_MODE_STRAP_BIT2,
  input wire logic MGMT_ADDRESS_STRAP,
  input wire logic SHARED_PIN_FUNCTION_STRAP,
  input wire logic REGULATOR_DISABLE_STRAP,
  output logic [2:0] OP_MODE,
  output logic [4:0] MGMT_ADDRESS,
  output logic REGULATOR_OFF,
  input wire logic SPEED_100,
  input wire logic FULL_DUPLEX,
  input wire logic LOOPBACK,
  input wire logic LINK_UP,
  input wire logic ISOLATE,
  input wire logic ACTIVITY,
  input wire logic INT_REQUEST,
  output logic LINK_ACTIVITY_INDICATOR,
  output logic SPEED_INDICATOR,
  output logic INTERRUPT_OUT_N,
  output logic SHARED_PIN_OE_N,
  output logic REFERENCE_CLOCK_OUT,
  input wire logic MDC,
  input wire logic MDIO_IN,
  output logic MDIO_OUT,
  output logic MDIO_OE_N
);
  // pin synchronisers: straps, reset, tx, management
  logic [11:0] pin_s1_reg;
  logic [11:0] pin_s2_reg;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pin_s1_reg <= 12'h000;
      pin_s2_reg <= 12'h000;
    end else begin
      pin_s1_reg <= {OP_MODE_STRAP_BIT2, OP_MODE_STRAP_BIT1, OP_MODE_STRAP_BIT0,
                     MGMT_ADDRESS_STRAP, SHARED_PIN_FUNCTION_STRAP, REGULATOR_DISABLE_STRAP,
                     SYSTEM_RESET_N, TX_DATA, TX_ENABLE, MDC, MDIO_IN};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  strap_t strap_pins;
  logic sys_rst_n;
  logic [1:0] tx_dibit_s;
  logic tx_en_s;
  logic mdc_s;
  logic mdio_s;
  assign strap_pins = strap_t'(pin_s2_reg[11:6]);
  assign sys_rst_n = pin_s2_reg[5]; // R13
  assign tx_dibit_s = pin_s2_reg[4:3];
  assign tx_en_s = pin_s2_reg[2];
  assign mdc_s = pin_s2_reg[1];
  assign mdio_s = pin_s2_reg[0];

  // strap capture window: power-on reset or system reset held low
  logic latch_pending_reg;
  strap_t strap_reg;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      latch_pending_reg <= 1'b1; // R7
    end else begin
      latch_pending_reg <= !sys_rst_n; // R7
    end
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      strap_reg <= '0;
    end else if (latch_pending_reg) begin
      strap_reg <= strap_pins; // R7 R16
    end
  end

  // strap-derived configuration outputs
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      OP_MODE <= 3'h0;
      MGMT_ADDRESS <= 5'h00;
      REGULATOR_OFF <= 1'b0;
      RX_DATA_OE_N <= 1'b1;
    end else begin
      OP_MODE <= strap_reg.op_mode; // R8
      MGMT_ADDRESS <= {`MGMT_ADDR_HIGH, strap_reg.mgmt_addr0}; // R9
      REGULATOR_OFF <= strap_reg.reg_off;
      RX_DATA_OE_N <= latch_pending_reg; // straps readable while released
    end
  end

  // transmit pass-through to the line side
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      TX_DIBIT_OUT <= 2'h0;
      TX_VALID_OUT <= 1'b0;
    end else begin
      TX_VALID_OUT <= tx_en_s; // R1
      TX_DIBIT_OUT <= tx_en_s ? tx_dibit_s : 2'h0; // R1
    end
  end

  // receive source: line, or loopback except at 10 Mbps half duplex
  logic echo_ok;
  logic src_valid;
  logic [1:0] src_dibit;
  logic src_err;
  assign echo_ok = LOOPBACK && (SPEED_100 || FULL_DUPLEX); // R6
  assign src_valid = echo_ok ? tx_en_s : LINE_VALID; // R6
  assign src_dibit = echo_ok ? tx_dibit_s : LINE_DIBIT;
  assign src_err = echo_ok ? 1'b0 : LINE_ERROR;

  // start-of-frame search and frame error memory
  logic [5:0] hist_reg;
  logic sfd_seen_reg;
  logic frame_err_reg;
  logic push_ok;
  logic sfd_now;
  assign sfd_now = ({hist_reg, src_dibit} == `SFD_DIBITS);
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      hist_reg <= 6'h00;
      sfd_seen_reg <= 1'b0;
    end else if (!LINE_ACTIVE && !echo_ok) begin
      hist_reg <= 6'h00;
      sfd_seen_reg <= 1'b0;
    end else if (src_valid && push_ok) begin
      hist_reg <= {hist_reg[3:0], src_dibit};
      sfd_seen_reg <= sfd_seen_reg || sfd_now; // R5
    end
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      frame_err_reg <= 1'b0;
    end else if (src_valid && src_err) begin
      frame_err_reg <= 1'b1; // R3
    end else if (!LINE_ACTIVE) begin
      frame_err_reg <= 1'b0;
    end
  end

  // word into the receive buffer
  rx_word_t in_word;
  rx_word_t out_word;
  logic out_valid;
  logic drain;
  logic data_gate;
  assign data_gate = SPEED_100 || sfd_seen_reg || sfd_now; // R5
  assign in_word.dibit = data_gate ? src_dibit : 2'h0; // R5
  assign in_word.err = src_err || frame_err_reg; // R3

  rx_fifo #(.WIDTH(`RX_FIFO_WIDTH), .DEPTH(`RX_FIFO_DEPTH)) u_rx_fifo (
    .clk(CORE_CLK),
    .rst(RST),
    .in_valid(src_valid),
    .in_ready(push_ok),
    .in_data(in_word),
    .out_valid(out_valid),
    .out_ready(drain),
    .out_data(out_word)
  );

  // line ready mirrors buffer room, held low while loopback echoes transmit
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      LINE_READY <= 1'b0;
    end else begin
      LINE_READY <= push_ok && !echo_ok;
    end
  end

  // drain rate: every cycle at 100, every tenth at 10
  logic [3:0] div_reg;
  logic tick;
  assign tick = SPEED_100 || (div_reg == 4'h0);
  assign drain = tick;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= (SPEED_100 || div_reg == `TEN_MBPS_DIV - 4'h1) ? 4'h0 : div_reg + 4'h1;
    end
  end

  // receive pins to the MAC
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      RX_DATA <= 2'h0;
      RX_ERROR <= 1'b0;
      CARRIER_DATA_VALID <= 1'b0;
    end else begin
      CARRIER_DATA_VALID <= LINE_ACTIVE || out_valid; // R4
      if (tick) begin
        RX_DATA <= out_valid ? out_word.dibit : 2'h0; // R2
        RX_ERROR <= out_valid && out_word.err; // R3
      end
    end
  end

  // activity hold and blink phase
  logic [31:0] blink_cnt_reg;
  logic blink_phase_reg;
  logic act_hold_reg;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      blink_cnt_reg <= '0;
      blink_phase_reg <= 1'b0;
      act_hold_reg <= 1'b0;
    end else if (blink_cnt_reg == 32'(BLINK_CYCLES - 1)) begin
      blink_cnt_reg <= '0;
      blink_phase_reg <= !blink_phase_reg;
      act_hold_reg <= ACTIVITY;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
      act_hold_reg <= act_hold_reg || ACTIVITY;
    end
  end

  // indicators
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      LINK_ACTIVITY_INDICATOR <= 1'b0;
      SPEED_INDICATOR <= 1'b0;
    end else begin
      LINK_ACTIVITY_INDICATOR <= LINK_UP && !(act_hold_reg && blink_phase_reg); // R10
      SPEED_INDICATOR <= SPEED_100 && !ISOLATE; // R11
    end
  end

  // shared pin: open-drain interrupt or reference clock enable
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      INTERRUPT_OUT_N <= 1'b1;
      SHARED_PIN_OE_N <= 1'b1;
      REFERENCE_CLOCK_OUT <= 1'b0;
    end else if (strap_reg.int_select) begin
      INTERRUPT_OUT_N <= 1'b0; // R12 R13
      SHARED_PIN_OE_N <= !INT_REQUEST; // R12
      REFERENCE_CLOCK_OUT <= 1'b0;
    end else begin
      INTERRUPT_OUT_N <= 1'b1;
      SHARED_PIN_OE_N <= latch_pending_reg; // R12
      REFERENCE_CLOCK_OUT <= !latch_pending_reg; // R15
    end
  end

  // management frame: answer reads to our address with zero data
  mgmt_state_t mg_state_reg;
  logic mdc_d_reg;
  logic [4:0] mg_cnt_reg;
  logic [12:0] mg_shift_reg;
  logic mdc_rise;
  logic [12:0] hdr;
  assign mdc_rise = mdc_s && !mdc_d_reg; // R14
  assign hdr = {mg_shift_reg[11:0], mdio_s};
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      mdc_d_reg <= 1'b0;
      mg_state_reg <= MG_IDLE;
      mg_cnt_reg <= 5'h00;
      mg_shift_reg <= 13'h0000;
      MDIO_OUT <= 1'b1;
      MDIO_OE_N <= 1'b1;
    end else begin
      mdc_d_reg <= mdc_s;
      if (mdc_rise) begin
        mg_shift_reg <= hdr;
        case (mg_state_reg)
          MG_IDLE: begin
            MDIO_OE_N <= 1'b1;
            mg_cnt_reg <= 5'h00;
            if (!mdio_s) begin
              mg_state_reg <= MG_HDR;
            end
          end
          MG_HDR: begin
            mg_cnt_reg <= mg_cnt_reg + 5'h01;
            if (mg_cnt_reg == `MGMT_HDR_BITS - 5'h01) begin
              mg_cnt_reg <= 5'h00;
              if (hdr[11:10] == `MGMT_OP_READ && hdr[9:5] == MGMT_ADDRESS) begin
                mg_state_reg <= MG_TA; // R9 R14
              end else begin
                mg_state_reg <= MG_IDLE;
              end
            end
          end
          MG_TA: begin
            MDIO_OUT <= 1'b0; // R14
            MDIO_OE_N <= 1'b0;
            mg_state_reg <= MG_DATA;
          end
          MG_DATA: begin
            mg_cnt_reg <= mg_cnt_reg + 5'h01;
            if (mg_cnt_reg == `MGMT_DATA_BITS) begin
              MDIO_OE_N <= 1'b1;
              MDIO_OUT <= 1'b1;
              mg_state_reg <= MG_IDLE;
            end
          end
          default: begin
            mg_state_reg <= MG_IDLE;
          end
        endcase
      end
    end
  end

  // checks
  sequence s_ten_pre_sfd;
    !SPEED_100 && !sfd_seen_reg && !sfd_now && src_valid && push_ok;
  endsequence
  sequence s_errored_frame;
    frame_err_reg && src_valid;
  endsequence
  property p_sfd_gate;
    @(posedge CORE_CLK) disable iff (RST) s_ten_pre_sfd |-> in_word.dibit == 2'h0;
  endproperty
  a_sfd_gate: assert property (p_sfd_gate) else $error("data before sfd not low"); // R5
  property p_frame_err;
    @(posedge CORE_CLK) disable iff (RST) s_errored_frame |-> in_word.err;
  endproperty
  a_frame_err: assert property (p_frame_err) else $error("frame error not carried"); // R3
  property p_carrier;
    @(posedge CORE_CLK) disable iff (RST) LINE_ACTIVE |=> CARRIER_DATA_VALID;
  endproperty
  a_carrier: assert property (p_carrier) else $error("carrier missing"); // R4
  property p_no_echo;
    @(posedge CORE_CLK) disable iff (RST)
      (!SPEED_100 && !FULL_DUPLEX && !LINE_VALID) |-> !src_valid;
  endproperty
  a_no_echo: assert property (p_no_echo) else $error("transmit echoed"); // R6
  property p_strap_hold;
    @(posedge CORE_CLK) disable iff (RST)
      (!latch_pending_reg ##1 !latch_pending_reg) |=> $stable(OP_MODE) && $stable(MGMT_ADDRESS);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed"); // R16
  property p_speed_led;
    @(posedge CORE_CLK) disable iff (RST)
      (SPEED_100 && !ISOLATE) [*2] |=> SPEED_INDICATOR;
  endproperty
  a_speed_led: assert property (p_speed_led) else $error("speed indicator off"); // R11
  property p_link_led;
    @(posedge CORE_CLK) disable iff (RST) !LINK_UP |=> !LINK_ACTIVITY_INDICATOR;
  endproperty
  a_link_led: assert property (p_link_led) else $error("link indicator on"); // R10
  property p_shared_pin;
    @(posedge CORE_CLK) disable iff (RST)
      strap_reg.int_select ##1 strap_reg.int_select |-> !REFERENCE_CLOCK_OUT;
  endproperty
  a_shared_pin: assert property (p_shared_pin) else $error("refclk in interrupt mode"); // R12
  property p_rx_order;
    @(posedge CORE_CLK) disable iff (RST)
      (tick && out_valid) |=> RX_DATA == $past(out_word.dibit);
  endproperty
  a_rx_order: assert property (p_rx_order) else $error("receive dibit order"); // R2
  property p_mode_map;
    @(posedge CORE_CLK) disable iff (RST)
      latch_pending_reg ##1 !latch_pending_reg |=> OP_MODE == $past(strap_reg.op_mode);
  endproperty
  a_mode_map: assert property (p_mode_map) else $error("mode field wrong"); // R8
endmodule

// ### core/pins_map.svh
`ifndef PINS_MAP_SVH
`define PINS_MAP_SVH

// core clock rate and derived cycle counts
`define CORE_CLK_HZ 25000000
`define BLINK_HALF_MS 40
`define BLINK_HALF_CYCLES ((`CORE_CLK_HZ / 1000) * `BLINK_HALF_MS)
// core cycles per receive dibit at 10 Mbps
`define TEN_MBPS_DIV 4'hA
// last four receive dibits of the start-of-frame byte, oldest in the top bits
`define SFD_DIBITS 8'h57
// management address: strap gives bit 0, upper bits fixed
`define MGMT_ADDR_HIGH 4'h0
// receive buffer shape
`define RX_FIFO_DEPTH 8
`define RX_FIFO_WIDTH 3
// management frame: bits after the first start bit up to turnaround
`define MGMT_HDR_BITS 5'hD
`define MGMT_DATA_BITS 5'h10
`define MGMT_OP_READ 2'h2

`endif

// ### core/pins_pkg.sv
package pins_pkg;
  // straps caught at reset
  typedef struct packed {
    logic [2:0] op_mode;
    logic mgmt_addr0;
    logic int_select;
    logic reg_off;
  } strap_t;
  // one receive transfer
  typedef struct packed {
    logic err;
    logic [1:0] dibit;
  } rx_word_t;
  typedef enum logic [1:0] {MG_IDLE, MG_HDR, MG_TA, MG_DATA} mgmt_state_t;
endpackage

// ### sim/mgmt_ctrl_model.sv
`timescale 1ns/10ps
// station management controller: drives the clock, shares the data line
module mgmt_ctrl_model (
  input wire logic clk,
  output logic mdc,
  output logic mdio_line,
  input wire logic mdio_out,
  input wire logic mdio_oe_n
);
  logic host_oe_n;
  logic host_bit;
  // shared data line with pull-up when nobody drives
  assign mdio_line = !mdio_oe_n ? mdio_out : (!host_oe_n ? host_bit : 1'b1);
  initial begin
    mdc = 1'b0;
    host_oe_n = 1'b1;
    host_bit = 1'b1;
  end
  // one management clock period, low phase then high phase
  task automatic half_high();
    repeat (8) @(negedge clk);
    mdc = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  // read frame: idle ones, start, op, address, register, then 17 bits back
  task automatic read(input logic [4:0] addr, output logic [16:0] got, output logic drove);
    logic [15:0] hdr;
    hdr = {2'h3, 2'h1, 2'h2, addr, 5'h01};
    drove = 1'b0;
    host_oe_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      host_bit = hdr[i];
      half_high();
      mdc = 1'b0;
    end
    host_oe_n = 1'b1;
    for (int i = 16; i >= 0; i--) begin
      half_high();
      got[i] = mdio_line;
      drove = drove | !mdio_oe_n;
      mdc = 1'b0;
    end
    // one idle period so the device lets go of the line
    half_high();
    mdc = 1'b0;
  endtask
endmodule

// ### sim/rmii_strap_led_pins_tb.sv
`timescale 1ns/10ps
module rmii_strap_led_pins_tb;
  logic clk, rst, sys_rst_n, tx_en, line_valid, line_err, line_active;
  logic [1:0] tx_data, line_dibit, tx_dout, rx_data, first_nz;
  logic m0, m1, m2, addr_strap, fn_strap, roff_strap;
  logic spd, fdx, lpbk, link, iso, act, int_req, mdc, mdio_in;
  logic tx_vout, line_rdy, rx_oe_n, rx_err, crs_dv, regulator_disable_strap, led_link, led_spd;
  logic int_n, sp_oe_n, refclk_en, mdio_out, mdio_oe_n, err_seen, link_off, drove;
  logic [2:0] op_mode;
  logic [4:0] mgmt_addr;
  logic [16:0] got;
  logic [1:0] seq [5];
  int bad_count, cmp_count, cycles;

  rmii_strap_led_pins #(.BLINK_CYCLES(8)) dut (
    .CORE_CLK(clk), .RST(rst), .SYSTEM_RESET_N(sys_rst_n),
    .TX_DATA(tx_data), .TX_ENABLE(tx_en), .TX_DIBIT_OUT(tx_dout), .TX_VALID_OUT(tx_vout),
    .LINE_DIBIT(line_dibit), .LINE_VALID(line_valid), .LINE_ERROR(line_err),
    .LINE_ACTIVE(line_active), .LINE_READY(line_rdy), .RX_DATA(rx_data),
    .RX_DATA_OE_N(rx_oe_n), .RX_ERROR(rx_err), .CARRIER_DATA_VALID(crs_dv),
    .OP_MODE_STRAP_BIT0(m0), .OP_MODE_STRAP_BIT1(m1), .OP_MODE_STRAP_BIT2(m2),
    .MGMT_ADDRESS_STRAP(addr_strap), .SHARED_PIN_FUNCTION_STRAP(fn_strap),
    .REGULATOR_DISABLE_STRAP(roff_strap), .OP_MODE(op_mode), .MGMT_ADDRESS(mgmt_addr),
    .REGULATOR_OFF(regulator_disable_strap), .SPEED_100(spd), .FULL_DUPLEX(fdx), .LOOPBACK(lpbk),
    .LINK_UP(link), .ISOLATE(iso), .ACTIVITY(act), .INT_REQUEST(int_req),
    .LINK_ACTIVITY_INDICATOR(led_link), .SPEED_INDICATOR(led_spd),
    .INTERRUPT_OUT_N(int_n), .SHARED_PIN_OE_N(sp_oe_n), .REFERENCE_CLOCK_OUT(refclk_en),
    .MDC(mdc), .MDIO_IN(mdio_in), .MDIO_OUT(mdio_out), .MDIO_OE_N(mdio_oe_n)
  );
  mgmt_ctrl_model mgmt (.clk(clk), .mdc(mdc), .mdio_line(mdio_in), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n));

  // 25 MHz core clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // receive and indicator watchers, plus hang guard
  always @(posedge clk) begin
    if (rx_data !== 2'h0 && first_nz === 2'h0) first_nz <= rx_data;
    if (rx_err === 1'b1) err_seen <= 1'b1;
    if (led_link === 1'b0) link_off <= 1'b1;
    cycles++;
    if (cycles == 10000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one received frame: preamble dibits, start byte end, one data dibit
  task automatic rx_frame(input logic s100, input logic [4:0] errs, input int gap);
    spd = s100;
    line_active = 1'b1;
    first_nz = 2'h0;
    err_seen = 1'b0;
    for (int i = 0; i < 5; i++) begin
      line_dibit = seq[i];
      line_err = errs[i];
      line_valid = 1'b1;
      wait_n(1);
      if (gap > 1) begin
        line_valid = 1'b0;
        wait_n(gap - 1);
      end
    end
    line_valid = 1'b0;
    line_err = 1'b0;
    chk(crs_dv === 1'b1, "carrier missing");
    wait_n(80);
    line_active = 1'b0;
    wait_n(4);
    chk(crs_dv === 1'b0, "carrier stuck");
  endtask
  // same dibits from the MAC, each held for ten cycles
  task automatic tx_frame();
    tx_en = 1'b1;
    for (int i = 0; i < 5; i++) begin
      tx_data = seq[i];
      wait_n(3);
      chk(tx_vout === 1'b1 && tx_dout === seq[i], "transmit dibit");
      wait_n(7);
    end
    tx_en = 1'b0;
    tx_data = 2'h0;
    wait_n(80);
  endtask

  // main sequence
  initial begin
    seq = '{2'h1, 2'h1, 2'h1, 2'h3, 2'h2};
    {rst, sys_rst_n, tx_en, tx_data, line_valid, line_err, line_active} = 8'h80;
    line_dibit = 2'h0;
    {m2, m1, m0, addr_strap, fn_strap, roff_strap} = 6'h2F;
    {spd, fdx, lpbk, link, iso, act, int_req} = 7'h00;
    {first_nz, err_seen, link_off} = 4'h0;
    bad_count = 0;
    cmp_count = 0;
    cycles = 0;
    wait_n(2);
    rst = 1'b0;
    wait_n(2);
    chk(rx_oe_n === 1'b1, "receive pins not released");
    sys_rst_n = 1'b1;
    wait_n(6);
    chk(op_mode === 3'h5, "mode field");
    chk(mgmt_addr === 5'h01, "address");
    chk(regulator_disable_strap === 1'b1 && rx_oe_n === 1'b0, "regulator strap");
    {m2, m1, m0, addr_strap, fn_strap, roff_strap} = 6'h30;
    wait_n(6);
    chk(op_mode === 3'h5 && mgmt_addr === 5'h01, "straps moved");
    chk(sp_oe_n === 1'b1 && refclk_en === 1'b0, "shared pin idle");
    int_req = 1'b1;
    wait_n(3);
    chk(sp_oe_n === 1'b0 && int_n === 1'b0, "interrupt low");
    int_req = 1'b0;
    wait_n(3);
    chk(sp_oe_n === 1'b1, "interrupt release");
    for (int i = 0; i < 4; i++) begin
      {spd, iso} = i[1:0];
      wait_n(3);
      chk(led_spd === (i == 2), "speed indicator");
    end
    link = 1'b1;
    wait_n(20);
    link_off = 1'b0;
    wait_n(20);
    chk(link_off === 1'b0 && led_link === 1'b1, "link steady");
    act = 1'b1;
    wait_n(20);
    act = 1'b0;
    chk(link_off === 1'b1, "no blink");
    link = 1'b0;
    wait_n(20);
    chk(led_link === 1'b0, "link off");
    rx_frame(1'b1, 5'h02, 1);
    chk(err_seen === 1'b1, "error lost");
    rx_frame(1'b1, 5'h00, 1);
    chk(err_seen === 1'b0, "error stuck");
    chk(first_nz === 2'h1, "bit order");
    rx_frame(1'b0, 5'h00, 10);
    chk(first_nz === 2'h3, "data before start byte");
    // fill the buffer at the slow drain rate, then let it empty
    line_active = 1'b1;
    line_dibit = 2'h2;
    line_valid = 1'b1;
    wait_n(12);
    line_valid = 1'b0;
    chk(line_rdy === 1'b0, "buffer never full");
    wait_n(120);
    chk(line_rdy === 1'b1, "buffer never empty");
    line_active = 1'b0;
    wait_n(4);
    lpbk = 1'b1;
    spd = 1'b0;
    for (int d = 0; d < 2; d++) begin
      fdx = d[0];
      first_nz = 2'h0;
      tx_frame();
      chk((first_nz !== 2'h0) === (d == 1), "loopback echo");
    end
    lpbk = 1'b0;
    sys_rst_n = 1'b0;
    wait_n(6);
    sys_rst_n = 1'b1;
    wait_n(6);
    chk(op_mode === 3'h6 && regulator_disable_strap === 1'b0, "system reset latch");
    chk(refclk_en === 1'b1 && sp_oe_n === 1'b0, "clock out mode");
    mgmt.read(5'h00, got, drove);
    chk(drove === 1'b1 && got === 17'h00000, "read answer");
    chk(mdio_oe_n === 1'b1, "management line held");
    mgmt.read(5'h01, got, drove);
    chk(drove === 1'b0 && got === 17'h1FFFF, "foreign address");
    wrap_up();
  end
endmodule
